// >>> pkg/dpw_pkg.sv
package dpw_pkg;

    // Register addresses as carried in the instruction byte
    localparam logic [4:0] ADDR_WIPER0 = 5'h00;
    localparam logic [4:0] ADDR_WIPER1 = 5'h01;
    localparam logic [4:0] ADDR_ACCESS = 5'h10;

    // Values after power-up preset
    localparam logic [7:0] WIPER_RST = 8'h80;
    localparam logic [7:0] ACCESS_RST = 8'h40;

    // Access control field positions and writable bits
    localparam int ACC_SDO_OD_BIT = 1;
    localparam int ACC_SHUTDOWN_N_BIT = 6;
    localparam logic [7:0] ACCESS_WMASK = 8'h42;

    // Opcodes in the top three bits of the instruction byte
    localparam logic [2:0] OPC_NO_OPERATION = 3'h0;
    localparam logic [2:0] OPC_ACC_READ = 3'h1;
    localparam logic [2:0] OPC_ACC_WRITE = 3'h3;
    localparam logic [2:0] OPC_REG_READ = 3'h4;
    localparam logic [2:0] OPC_REG_WRITE = 3'h6;

    // Marker sent ahead of the address in a chained read answer
    localparam logic [2:0] CHAIN_CODE = 3'h7;

    // Bits in one transaction word (instruction plus data)
    localparam logic [3:0] WORD_LAST_BIT = 4'hF;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

    // Decoded register target
    localparam logic [1:0] TGT_NONE = 2'h0;
    localparam logic [1:0] TGT_WIPER = 2'h1;
    localparam logic [1:0] TGT_ACCESS = 2'h2;

    // Instruction byte layout
    typedef struct packed {
        logic [2:0] opc;
        logic [4:0] addr;
    } dpw_instr_s;

    // One-cycle write request towards the register file
    typedef struct packed {
        logic       en;
        dpw_instr_s instr;
        logic [7:0] data;
    } dpw_wr_s;

    // Register a read or write instruction reaches
    function automatic logic [1:0] dpw_target(input dpw_instr_s i);
        logic [1:0] t;
        t = TGT_NONE;
        if (i.opc == OPC_ACC_READ || i.opc == OPC_ACC_WRITE)
        begin
            t = TGT_ACCESS;
        end
        else if (i.opc == OPC_REG_READ || i.opc == OPC_REG_WRITE)
        begin
            if (i.addr == ADDR_WIPER0 || i.addr == ADDR_WIPER1)
                t = TGT_WIPER;
            else if (i.addr == ADDR_ACCESS)
                t = TGT_ACCESS;
        end
        return t;
    endfunction : dpw_target

    // True for the two read opcodes
    function automatic logic dpw_is_read(input dpw_instr_s i);
        return (i.opc == OPC_ACC_READ) || (i.opc == OPC_REG_READ);
    endfunction : dpw_is_read

    // True for the two write opcodes
    function automatic logic dpw_is_write(input dpw_instr_s i);
        return (i.opc == OPC_ACC_WRITE) || (i.opc == OPC_REG_WRITE);
    endfunction : dpw_is_write

endpackage : dpw_pkg

// >>> hdl/dpw_regfile.sv
`timescale 1ns/1ns
module dpw_regfile
(
    input  wire logic              core_clk,   // System clock
    input  wire logic              sys_rst,    // Power-up preset, sync high
    input  wire dpw_pkg::dpw_wr_s  wr_req,     // Committed write, one cycle
    input  wire dpw_pkg::dpw_instr_s rd_instr, // Instruction being answered
    output logic [7:0]             rd_data_ff, // Registered read data
    output logic [7:0]             wiper_ff,   // Wiper position register
    output logic [7:0]             access_ff   // Access control register
);

    ////////////////////////////////////////////////////////////////////////
    // Wiper position: preset to mid-scale, kept through shutdown
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            wiper_ff <= dpw_pkg::WIPER_RST;
        else if (wr_req.en && dpw_pkg::dpw_target(wr_req.instr) == dpw_pkg::TGT_WIPER)
            wiper_ff <= wr_req.data;
    end

    // Access control: unused bits never store a one
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            access_ff <= dpw_pkg::ACCESS_RST;
        else if (wr_req.en && dpw_pkg::dpw_target(wr_req.instr) == dpw_pkg::TGT_ACCESS)
            access_ff <= wr_req.data & dpw_pkg::ACCESS_WMASK;
    end

    // Read mux; unmapped addresses read as zero
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rd_data_ff <= 8'h00;
        else
        begin
            case (dpw_pkg::dpw_target(rd_instr))
                dpw_pkg::TGT_WIPER:  rd_data_ff <= wiper_ff;
                dpw_pkg::TGT_ACCESS: rd_data_ff <= access_ff;
                default:             rd_data_ff <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_acc_reserved: assert property (@(posedge core_clk) disable iff (sys_rst)
        (access_ff & ~dpw_pkg::ACCESS_WMASK) == 8'h00)
        else $error("reserved access bit set");

    a_wiper_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_req.en && wr_req.instr.opc == dpw_pkg::OPC_REG_WRITE && wr_req.instr.addr == dpw_pkg::ADDR_WIPER1
        |=> wiper_ff == $past(wr_req.data))
        else $error("wiper write to address 1 lost");

endmodule : dpw_regfile

// >>> hdl/dpw_core.sv
`timescale 1ns/1ns
module dpw_core
(
    input  wire logic  core_clk,        // System clock, 250 MHz
    input  wire logic  sys_rst,         // Power-up preset, sync high
    input  wire logic  sck,             // Serial clock pin
    input  wire logic  cs_n,            // Select pin, active low
    input  wire logic  sdi,             // Serial data in pin
    output logic       sdo_level,       // Serial data out level
    output logic       sdo_oe_n,        // Output enable, low drives
    output logic [7:0] wiper_tap,       // Tap code to the array
    output logic       shutdown,        // Array open, wiper tied low
    output logic       standby          // Deselected, low power
);

    ////////////////////////////////////////////////////////////////////////
    // Session states
    typedef enum logic [2:0] {
        ST_WAIT_HIGH = 3'h1,  // After preset, select not yet seen high
        ST_IDLE      = 3'h2,  // Deselected
        ST_ACTIVE    = 3'h4   // Selected, shifting
    } dpw_state_e;

    dpw_state_e          state_ff;     // Session state
    logic [2:0]          sck_sync_ff;  // Clock synchroniser plus history
    logic [2:0]          cs_sync_ff;   // Select synchroniser plus history
    logic [1:0]          sdi_sync_ff;  // Data synchroniser
    logic [15:0]         rx_ff;        // Last word received
    logic [15:0]         tx_ff;        // Word going out
    logic [3:0]          bit_ff;       // Bit within word
    logic                first_ff;     // Still in first word of session
    logic                word_ff;      // A whole word has arrived
    logic                upd_ff;       // Present first bit after select
    dpw_pkg::dpw_instr_s instr_ff;     // First instruction of session
    logic                pend_ff;      // Read left for next session
    dpw_pkg::dpw_instr_s pend_instr_ff;// Its instruction
    dpw_pkg::dpw_wr_s    wr_req_ff;    // Commit pulse
    logic [7:0]          rd_data;      // Register read data
    logic [7:0]          wiper_q;      // Stored wiper position
    logic [7:0]          access_q;     // Access control register
    logic                sck_rise;
    logic                sck_fall;
    logic                cs_fall;
    logic                cs_rise;
    logic                od_mode;
    logic                imm_load;
    dpw_pkg::dpw_instr_s rx_instr;
    dpw_pkg::dpw_instr_s first_instr;

    ////////////////////////////////////////////////////////////////////////
    // Pins cross into core_clk through two flops; stage two is read, stage three only for edges
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sck_sync_ff <= 3'h0;
            // Low history makes the wait state see a real high; the false rise is ignored
            cs_sync_ff  <= 3'h0;
            sdi_sync_ff <= 2'h0;
        end
        else
        begin
            sck_sync_ff <= {sck_sync_ff[1:0], sck};
            cs_sync_ff  <= {cs_sync_ff[1:0], cs_n};
            sdi_sync_ff <= {sdi_sync_ff[0], sdi};
        end
    end

    // Edges from stage two against stage three
    assign sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
    assign sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
    assign cs_fall  = ~cs_sync_ff[1] & cs_sync_ff[2];
    assign cs_rise  = cs_sync_ff[1] & ~cs_sync_ff[2];
    assign od_mode  = access_q[dpw_pkg::ACC_SDO_OD_BIT];
    assign rx_instr = rx_ff[15:8];
    assign first_instr = {rx_ff[6:0], sdi_sync_ff[1]};
    // An immediate read answer replaces pass-through at end of word one
    assign imm_load = first_ff && bit_ff == dpw_pkg::WORD_LAST_BIT && dpw_pkg::dpw_is_read(instr_ff);

    ////////////////////////////////////////////////////////////////////////
    // Session control; a select fall before select is seen high is ignored
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            state_ff <= ST_WAIT_HIGH;
        else
        begin
            case (state_ff)
                ST_WAIT_HIGH: if (cs_sync_ff[1]) state_ff <= ST_IDLE;
                ST_IDLE:      if (cs_fall) state_ff <= ST_ACTIVE;
                ST_ACTIVE:    if (cs_rise) state_ff <= ST_IDLE;
                default:      state_ff <= ST_WAIT_HIGH;
            endcase
        end
    end

    // Receive side: shift on clock rise only while selected
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || state_ff != ST_ACTIVE)
        begin
            rx_ff    <= 16'h0000;
            bit_ff   <= 4'h0;
            first_ff <= 1'b1;
            word_ff  <= 1'b0;
            instr_ff <= '0;
        end
        else if (sck_rise)
        begin
            rx_ff  <= {rx_ff[14:0], sdi_sync_ff[1]};
            bit_ff <= bit_ff + 4'h1;
            if (first_ff && bit_ff == dpw_pkg::BYTE_LAST_BIT)
                instr_ff <= first_instr;
            if (bit_ff == dpw_pkg::WORD_LAST_BIT)
            begin
                first_ff <= 1'b0;
                word_ff  <= 1'b1;
            end
        end
    end

    // Transmit word: pass-through, or a read answer loaded in its place
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            tx_ff <= 16'h0000;
        else if (state_ff == ST_IDLE && cs_fall)
            tx_ff <= pend_ff ? {dpw_pkg::CHAIN_CODE, pend_instr_ff.addr, rd_data} : 16'h0000;
        else if (state_ff == ST_ACTIVE && sck_rise)
        begin
            if (imm_load)
                tx_ff <= {instr_ff, rd_data};
            else
                tx_ff <= {tx_ff[14:0], sdi_sync_ff[1]};
        end
    end

    // First output bit appears one cycle after select falls
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            upd_ff <= 1'b0;
        else
            upd_ff <= state_ff == ST_IDLE && cs_fall;
    end

    // Output pin: changes on clock fall; released while deselected
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || state_ff != ST_ACTIVE || cs_rise)
        begin
            sdo_level <= 1'b0;
            sdo_oe_n  <= 1'b1;
        end
        else if (sck_fall || upd_ff)
        begin
            // Open drain only pulls low; a one leaves the pin to the pull-up
            sdo_level <= od_mode ? 1'b0 : tx_ff[15];
            sdo_oe_n  <= od_mode ? tx_ff[15] : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commit on select rise, from the last whole word only
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            wr_req_ff <= '0;
        else
        begin
            wr_req_ff.en    <= state_ff == ST_ACTIVE && cs_rise && word_ff && bit_ff == 4'h0
                               && dpw_pkg::dpw_is_write(rx_instr);
            wr_req_ff.instr <= rx_instr;
            wr_req_ff.data  <= rx_ff[7:0];
        end
    end

    // A read left last in a session is answered at the next select fall
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pend_ff       <= 1'b0;
            pend_instr_ff <= '0;
        end
        else if (state_ff == ST_ACTIVE && cs_rise)
        begin
            pend_ff       <= word_ff && bit_ff == 4'h0 && dpw_pkg::dpw_is_read(rx_instr);
            pend_instr_ff <= rx_instr;
        end
        else if (state_ff == ST_IDLE && cs_fall)
            pend_ff <= 1'b0;
    end

    // Register file; read select follows whichever answer is due
    dpw_regfile u_regs
    (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .wr_req     (wr_req_ff),
        .rd_instr   (pend_ff ? pend_instr_ff : instr_ff),
        .rd_data_ff (rd_data),
        .wiper_ff   (wiper_q),
        .access_ff  (access_q)
    );

    // Analog-facing outputs; shutdown leaves the stored code alone
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wiper_tap <= dpw_pkg::WIPER_RST;
            shutdown  <= 1'b0;
            standby   <= 1'b1;
        end
        else
        begin
            wiper_tap <= wiper_q;
            shutdown  <= ~access_q[dpw_pkg::ACC_SHUTDOWN_N_BIT];
            standby   <= state_ff != ST_ACTIVE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_sel_with_pending;
        state_ff == ST_IDLE && cs_fall && pend_ff;
    endsequence

    sequence s_chain_header;
        ##1 tx_ff[15:13] == dpw_pkg::CHAIN_CODE && tx_ff[12:8] == $past(pend_instr_ff.addr);
    endsequence

    a_chain_code: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_sel_with_pending |-> s_chain_header)
        else $error("chained answer header wrong");

    a_wiper_preset: assert property (@(posedge core_clk)
        sys_rst |=> wiper_tap == dpw_pkg::WIPER_RST)
        else $error("wiper not preset to mid-scale");

    a_sdo_release: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_ACTIVE && cs_rise |=> sdo_oe_n && standby == 1'b0 ##1 standby)
        else $error("output not released on deselect");

    a_sample_sel: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff != ST_ACTIVE |=> rx_ff == 16'h0000)
        else $error("bits taken while deselected");

    a_sdo_fall: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_ACTIVE && !sck_fall && !upd_ff && !cs_rise |=> $stable({sdo_level, sdo_oe_n}))
        else $error("output changed away from falling edge");

    a_od_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
        od_mode && state_ff == ST_ACTIVE && sck_fall && !cs_rise |=> !sdo_level && sdo_oe_n == $past(tx_ff[15]))
        else $error("open drain drives high");

    a_commit_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_req_ff.en |-> $past(cs_rise) && $past(state_ff) == ST_ACTIVE)
        else $error("write committed before select rise");

    a_shutdown_out: assert property (@(posedge core_clk) disable iff (sys_rst)
        ##1 shutdown == !$past(access_q[dpw_pkg::ACC_SHUTDOWN_N_BIT]))
        else $error("shutdown output does not follow access bit 6");

    a_pass_through: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_ACTIVE && sck_rise && !imm_load |=> tx_ff[0] == $past(sdi_sync_ff[1]))
        else $error("input bit not passed along");

    a_wait_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_WAIT_HIGH && !cs_sync_ff[1] |=> state_ff != ST_ACTIVE)
        else $error("session began without select high first");

endmodule : dpw_core

// >>> verif/dpw_host.sv
`timescale 1ns/1ns
module dpw_host
(
    input  wire logic core_clk, // System clock
    input  wire logic sdo_line, // Resolved serial output wire
    output logic      sck,      // Serial clock, idle low
    output logic      cs_n,     // Select, active low
    output logic      sdi       // Serial data towards the device
);
    localparam int HALF = 8; // 32 ns half period of the 64 ns link clock
    logic idle;              // Session closed, data line released

    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
        idle = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Released data line toggles, so a stale bit never looks valid
    always @(posedge core_clk)
    begin
        if (idle)
            sdi <= ~sdi;
    end

    ////////////////////////////////////////////////////////////////
    // One framed session of whole words; clock stands still outside it
    task automatic session(input logic [15:0] tx[$], output logic [15:0] rx[$]);
        logic [15:0] w;
        rx = {};
        @(posedge core_clk);
        idle <= 1'b0;
        cs_n <= 1'b0;
        repeat (HALF) @(posedge core_clk);
        foreach (tx[k])
        begin
            for (int b = 15; b >= 0; b--)
            begin
                sdi <= tx[k][b];
                repeat (HALF) @(posedge core_clk);
                sck <= 1'b1;
                w[b] = sdo_line;
                repeat (HALF) @(posedge core_clk);
                sck <= 1'b0;
            end
            rx.push_back(w);
        end
        repeat (HALF) @(posedge core_clk);
        cs_n <= 1'b1;
        idle <= 1'b1;
        repeat (2 * HALF) @(posedge core_clk);
    endtask : session
endmodule : dpw_host

// >>> verif/dpw_core_tb.sv
`timescale 1ns/1ns
module dpw_core_tb;
    logic        core_clk;  // 250 MHz system clock
    logic        sys_rst;   // Power-up preset
    logic        sck;       // Link clock from the host
    logic        cs_n;      // Select from the host
    logic        sdi;       // Data from the host
    logic        sdo_level; // Output level
    logic        sdo_oe_n;  // Output enable, low drives
    logic        sdo_line;  // Wire with bench pull-up
    logic [7:0]  wiper_tap; // Tap code
    logic        shutdown;  // Array open
    logic        standby;   // Deselected
    int          bad_count; // Mismatches
    int          n_tests;   // Comparisons
    logic [7:0]  m_wiper;   // Model wiper register
    logic [7:0]  m_acc;     // Model access control register
    logic        m_pend;    // Model: read left pending for next session
    logic [15:0] m_pword;   // Model: the pending read word
    logic [15:0] tx[$];     // Words sent
    logic [15:0] rx[$];     // Words seen

    // Pull-up resolves both the released and the open-drain wire
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo_level;

    dpw_core u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .sdi(sdi),
                    .sdo_level(sdo_level), .sdo_oe_n(sdo_oe_n), .wiper_tap(wiper_tap), .shutdown(shutdown),
                    .standby(standby));
    dpw_host u_host (.core_clk(core_clk), .sdo_line(sdo_line), .sck(sck), .cs_n(cs_n), .sdi(sdi));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Single-bit outputs: standby, shutdown and the output pin pair
    task automatic chk_pin(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_pin

    // Eight-bit tap code towards the array
    task automatic chk_tap(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_tap

    // Model read answer for one instruction word; unmapped reads zero
    function automatic logic [7:0] m_read(input logic [15:0] w);
        if (w[15:13] == 3'h1 || (w[15:13] == 3'h4 && w[12:8] == 5'h10))
            return m_acc;
        if (w[15:13] == 3'h4 && w[12:9] == 4'h0)
            return m_wiper;
        return 8'h00;
    endfunction : m_read

    ////////////////////////////////////////////////////////////////
    // One session, then the model commits only the last word
    task automatic run();
        logic [15:0] e;
        logic [15:0] w;
        u_host.session(tx, rx);
        foreach (tx[k])
        begin
            if (k == 0)
                e = m_pend ? {3'h7, m_pword[12:8], m_read(m_pword)} : 16'h0000;
            else if (k == 1 && (tx[0][15:13] == 3'h1 || tx[0][15:13] == 3'h4))
                e = {tx[0][15:8], m_read(tx[0])};
            else
                e = tx[k - 1];
            chk("sdo word", e, rx[k]);
        end
        w = tx[tx.size() - 1];
        m_pend = (w[15:13] == 3'h1 || w[15:13] == 3'h4);
        m_pword = w;
        if (w[15:13] == 3'h3 || (w[15:13] == 3'h6 && w[12:8] == 5'h10))
            m_acc = w[7:0] & 8'h42;
        else if (w[15:13] == 3'h6 && w[12:9] == 4'h0)
            m_wiper = w[7:0];
        chk_tap("wiper_tap", m_wiper, wiper_tap);
        chk_pin("shutdown", ~m_acc[6], shutdown);
        chk_pin("standby", 1'b1, standby);
        chk_pin("sdo_oe_n", 1'b1, sdo_oe_n);
        if (m_acc[1])
            chk_pin("sdo_level", 1'b0, sdo_level);
    endtask : run

    // Four-byte read: instruction, dummy, no-op, dummy
    task automatic rd4(input logic [7:0] instr);
        tx = {{instr, 8'h00}, 16'h0000};
        run();
    endtask : rd4

    task automatic wr(input logic [7:0] instr, input logic [7:0] d);
        tx = {{instr, d}};
        run();
    endtask : wr

    ////////////////////////////////////////////////////////////////
    // Watchdog well above the roughly 12k cycles the tests need
    initial
    begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        test_done();
    end

    // Inside a session: standby low, and the pin pair in the mode the model holds
    always @(posedge sck)
    begin
        chk_pin("standby in session", 1'b0, standby);
        if (m_acc[1])
            chk_pin("sdo_level open drain", 1'b0, sdo_level);
        else
            chk_pin("sdo_oe_n push-pull", 1'b0, sdo_oe_n);
    end

    initial
    begin
        logic [31:0] r;
        sys_rst = 1'b1;
        bad_count = 0;
        n_tests = 0;
        m_wiper = 8'h80;
        m_acc = 8'h40;
        m_pend = 1'b0;
        m_pword = 16'h0000;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk_tap("wiper_tap", 8'h80, wiper_tap);
        chk_pin("standby", 1'b1, standby);
        r = $urandom(31083);
        rd4(8'h80);
        rd4(8'h90);
        rd4(8'h3F);
        // Random codes alternate between both wiper addresses
        for (int i = 0; i < 4; i++)
        begin
            r = $urandom;
            wr(8'hC0 | 8'(i & 1), r[7:0]);
            rd4(8'h81 ^ 8'(i & 1));
        end
        wr(8'hC0, 8'h00);
        wr(8'hC1, 8'hFF);
        wr(8'hC5, 8'h33);
        rd4(8'h85);
        wr(8'h60, 8'hFF);
        rd4(8'h90);
        wr(8'hD0, 8'h00);
        wr(8'hC0, 8'h5A);
        rd4(8'h80);
        wr(8'hD0, 8'h40);
        // Two-word write: only the last word lands, the first passes on
        tx = {16'hC011, 16'hC022};
        run();
        r = $urandom;
        tx = {{3'h0, r[12:0]}};
        run();
        // Chained read across two sessions
        tx = {16'h8100};
        run();
        r = $urandom;
        tx = {{3'h0, r[12:0]}, {3'h0, r[28:16]}};
        run();
        // Mid-run preset after moving both registers off their defaults
        wr(8'h60, 8'h02);
        sys_rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        m_wiper = 8'h80;
        m_acc = 8'h40;
        m_pend = 1'b0;
        repeat (6) @(posedge core_clk);
        chk_tap("wiper_tap", 8'h80, wiper_tap);
        chk_pin("shutdown", 1'b0, shutdown);
        rd4(8'h80);
        rd4(8'h3F);
        test_done();
    end
endmodule : dpw_core_tb
